// ==== add_alu.sv ====
`timescale 1ns/1ns
`include "add_alu_regs.svh"
`default_nettype none
module add_alu
  import add_alu_pkg::*;
(
  input  wire logic     clk_sys_in,   // 25 MHz instruction clock
  input  wire logic     rst_b_in,     // Async reset, active low
  input  wire instr_t   instr_in,     // Decoded instruction word and valid
  input  wire bus_req_t bus_in,       // Register port request
  output logic [15:0]   bus_rdata_out, // Read data, cycle after read
  output logic          done_out,     // Instruction retired pulse
  output logic          illegal_out,  // Unknown encoding pulse
  output logic [15:0]   sr_out,       // Status register
  output acc_t          first_accumulator_out,  // First accumulator
  output acc_t          second_accumulator_out  // Second accumulator
);

  logic [15:0] w_ff [16];
  logic [15:0] nxt_w [16];
  logic [15:0] mem_ff [`MEM_WORDS];
  logic [15:0] nxt_mem [`MEM_WORDS];
  acc_t        acc_ff [2];
  acc_t        nxt_acc [2];
  logic [15:0] sr_ff, nxt_sr;
  logic        done_ff, nxt_done;
  logic        illegal_ff, nxt_illegal;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [23:0] iw;
  logic        is_tri, is_acc, is_sac, is_file, is_lit, byte_op, cin;
  logic [15:0] opb, sval;
  alu_res_t    res;
  ea_t         sea, dea;
  acc_t        ext, sh, sum;

  // Word-width and byte-width add with all arithmetic flags
  function automatic alu_res_t add16(input logic [15:0] a, input logic [15:0] b,
                                     input logic ci, input logic bw);
    logic [16:0] sw;
    logic [8:0]  sb;
    logic [4:0]  s4;
    alu_res_t    r;
    sw = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
    sb = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, ci};
    s4 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    r.sum   = bw ? {8'h00, sb[7:0]} : sw[15:0];
    r.c     = bw ? sb[8] : sw[16];
    r.digit = bw ? s4[4] : sb[8];
    r.n     = bw ? sb[7] : sw[15];
    r.ovf   = bw ? ((a[7] == b[7]) && (sb[7] != a[7])) : ((a[15] == b[15]) && (sw[15] != a[15]));
    r.z     = bw ? (sb[7:0] == 8'h00) : (sw[15:0] == 16'h0000);
    return r;
  endfunction : add16
  // Load flags; a carry form can only clear zero
  function automatic logic [15:0] alu_flags(input logic [15:0] sr, input alu_res_t r,
                                            input logic sticky);
    logic [15:0] f;
    f            = sr;
    f[`SR_C]     = r.c;
    f[`SR_DIGIT] = r.digit;
    f[`SR_OVF]   = r.ovf;
    f[`SR_N]     = r.n;
    f[`SR_Z]     = sticky ? (sr[`SR_Z] & r.z) : r.z;
    return f;
  endfunction : alu_flags
  // Accumulator flags; saturation bits are sticky until software clears them
  function automatic logic [15:0] acc_flags(input logic [15:0] sr, input logic sel,
                                            input acc_t a, input acc_t b, input acc_t s);
    logic [15:0] f;
    logic        ovg, ovs;
    f   = sr;
    ovg = !((&s[39:31]) || !(|s[39:31]));
    ovs = (a[39] == b[39]) && (s[39] != a[39]);
    f[`SR_OVF_2ND] = sel ? ovg : f[`SR_OVF_2ND];
    f[`SR_SAT_2ND] = f[`SR_SAT_2ND] | (sel & ovs);
    f[`SR_OVF_1ST] = sel ? f[`SR_OVF_1ST] : ovg;
    f[`SR_SAT_1ST] = f[`SR_SAT_1ST] | (!sel & ovs);
    f[`SR_OVF_ANY] = f[`SR_OVF_1ST] | f[`SR_OVF_2ND];
    f[`SR_SAT_ANY] = f[`SR_SAT_1ST] | f[`SR_SAT_2ND];
    return f;
  endfunction : acc_flags
  // Effective address and new pointer; byte steps by one
  function automatic ea_t ind_mod(input logic [2:0] m, input logic [15:0] v, input logic bw);
    logic [15:0] st;
    ea_t         e;
    st = bw ? 16'h0001 : 16'h0002;
    e.ea = v;
    e.nv = v;
    unique case (m)
      `MODE_PODEC: e.nv = v - st;
      `MODE_POINC: e.nv = v + st;
      `MODE_PRDEC:
      begin
        e.nv = v - st;
        e.ea = e.nv;
      end
      `MODE_PRINC:
      begin
        e.nv = v + st;
        e.ea = e.nv;
      end
      default: e.nv = v;
    endcase
    return e;
  endfunction : ind_mod
  // Memory is word-wide; odd byte addresses take the upper lane
  function automatic logic [15:0] mem_rd(input logic [15:0] ea, input logic bw);
    logic [15:0] d;
    d = mem_ff[ea[8:1]];
    return bw ? {8'h00, (ea[0] ? d[15:8] : d[7:0])} : d;
  endfunction : mem_rd
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] v,
                                        input logic bw, input logic hi);
    return bw ? (hi ? {v[7:0], old[7:0]} : {old[15:8], v[7:0]}) : v;
  endfunction : merge
  // Opcode decode
  assign iw      = instr_in.word;
  assign byte_op = iw[14];
  assign is_tri  = (iw[23:20] == `OPC_TRI);
  assign is_acc  = (iw[23:16] == `OPC_ACC) && (iw[14:0] == 15'h0000);
  assign is_sac  = (iw[23:16] == `OPC_SAC);
  assign is_file = (iw[23:16] == `OPC_FILE);
  assign is_lit  = (iw[23:16] == `OPC_LIT);
  assign cin     = (is_tri ? iw[19] : iw[15]) & sr_ff[`SR_C];
  // Whole instruction in one pass; register port writes applied last
  always_comb
  begin
    nxt_w       = w_ff;
    nxt_mem     = mem_ff;
    nxt_acc     = acc_ff;
    nxt_sr      = sr_ff;
    nxt_done    = instr_in.valid;
    nxt_illegal = 1'b0;
    opb         = 16'h0000;
    sval        = 16'h0000;
    sea         = '{ea: 16'h0000, nv: 16'h0000};
    dea         = '{ea: 16'h0000, nv: 16'h0000};
    res         = add16(16'h0000, 16'h0000, 1'b0, 1'b0);
    ext         = 40'h00_0000_0000;
    sh          = 40'h00_0000_0000;
    sum         = 40'h00_0000_0000;
    if (instr_in.valid && is_tri)
    begin
      if (iw[6:5] == 2'b11)
        opb = {11'h000, iw[4:0]};
      else
      begin
        sea = ind_mod(iw[6:4], w_ff[iw[3:0]], byte_op);
        nxt_w[iw[3:0]] = sea.nv;
        opb = (iw[6:4] == `MODE_DIR) ? w_ff[iw[3:0]] : mem_rd(sea.ea, byte_op);
      end
      res = add16(w_ff[iw[18:15]], opb, cin, byte_op);
      if (iw[13:12] == 2'b11)
        nxt_illegal = 1'b1;
      else
      begin
        nxt_sr = alu_flags(sr_ff, res, iw[19]);
        if (iw[13:11] == `MODE_DIR)
          nxt_w[iw[10:7]] = merge(nxt_w[iw[10:7]], res.sum, byte_op, 1'b0);
        else
        begin
          dea = ind_mod(iw[13:11], nxt_w[iw[10:7]], byte_op);
          nxt_w[iw[10:7]] = dea.nv;
          nxt_mem[dea.ea[8:1]] = merge(mem_ff[dea.ea[8:1]], res.sum, byte_op, dea.ea[0]);
        end
      end
      if (nxt_illegal)
        nxt_w = w_ff;
    end
    else if (instr_in.valid && is_file)
    begin
      res    = add16(w_ff[0], mem_rd({3'b000, iw[12:0]}, byte_op), cin, byte_op);
      nxt_sr = alu_flags(sr_ff, res, iw[15]);
      if (iw[13])
        nxt_mem[iw[8:1]] = merge(mem_ff[iw[8:1]], res.sum, byte_op, iw[0]);
      else
        nxt_w[0] = merge(w_ff[0], res.sum, byte_op, 1'b0);
    end
    else if (instr_in.valid && is_lit)
    begin
      res = add16(w_ff[iw[3:0]], {6'h00, iw[13:4]}, cin, byte_op);
      nxt_sr = alu_flags(sr_ff, res, iw[15]);
      nxt_w[iw[3:0]] = merge(w_ff[iw[3:0]], res.sum, byte_op, 1'b0);
    end
    else if (instr_in.valid && is_acc)
    begin
      sum = acc_ff[0] + acc_ff[1];
      nxt_acc[iw[15]] = sum;
      nxt_sr = acc_flags(sr_ff, iw[15], acc_ff[0], acc_ff[1], sum);
    end
    else if (instr_in.valid && is_sac)
    begin
      if (iw[6:5] == 2'b11)
        sval = mem_rd(w_ff[iw[3:0]] + w_ff[iw[14:11]], 1'b0);
      else
      begin
        sea = ind_mod(iw[6:4], w_ff[iw[3:0]], 1'b0);
        nxt_w[iw[3:0]] = sea.nv;
        sval = (iw[6:4] == `MODE_DIR) ? w_ff[iw[3:0]] : mem_rd(sea.ea, 1'b0);
      end
      ext = {{8{sval[15]}}, sval, 16'h0000};
      // Shift affects only the operand copy, never the register
      sh  = iw[10] ? (ext << (4'h0 - iw[10:7])) : acc_t'($signed(ext) >>> iw[9:7]);
      sum = acc_ff[iw[15]] + sh;
      nxt_acc[iw[15]] = sum;
      nxt_sr = acc_flags(sr_ff, iw[15], acc_ff[iw[15]], sh, sum);
    end
    else if (instr_in.valid)
      nxt_illegal = 1'b1;
    if (bus_in.wr)
    begin
      if (bus_in.addr[9:4] == 6'h00)
        nxt_w[bus_in.addr[3:0]] = bus_in.wdata;
      else if (bus_in.addr == `ADR_SR)
        nxt_sr = bus_in.wdata | (nxt_sr & ~sr_ff & `SAT_MASK); // A new saturation beats a clear
      else if (bus_in.addr[`MEM_BIT])
        nxt_mem[bus_in.addr[7:0]] = bus_in.wdata;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      w_ff       <= '{default: 16'h0000};
      mem_ff     <= '{default: 16'h0000};
      acc_ff     <= '{default: 40'h00_0000_0000};
      sr_ff      <= `SR_RST;
      done_ff    <= 1'b0;
      illegal_ff <= 1'b0;
    end
    else
    begin
      w_ff       <= nxt_w;
      mem_ff     <= nxt_mem;
      acc_ff     <= nxt_acc;
      sr_ff      <= nxt_sr;
      done_ff    <= nxt_done;
      illegal_ff <= nxt_illegal;
    end
  end

  // Register port read; data shows the state before this cycle's update
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (bus_in.rd)
    begin
      if (bus_in.addr[9:4] == 6'h00)
        nxt_rdata = w_ff[bus_in.addr[3:0]];
      else if (bus_in.addr == `ADR_SR)
        nxt_rdata = sr_ff;
      else if (bus_in.addr[9:3] == 7'((`ADR_ACC) >> 3))
      begin
        unique case (bus_in.addr[1:0])
          2'h0: nxt_rdata = acc_ff[bus_in.addr[2]][15:0];
          2'h1: nxt_rdata = acc_ff[bus_in.addr[2]][31:16];
          2'h2: nxt_rdata = {8'h00, acc_ff[bus_in.addr[2]][39:32]};
          2'h3: nxt_rdata = 16'h0000;
        endcase
      end
      else if (bus_in.addr[`MEM_BIT])
        nxt_rdata = mem_ff[bus_in.addr[7:0]];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rdata_ff <= 16'h0000;
    else
      rdata_ff <= nxt_rdata;
  end
  assign bus_rdata_out          = rdata_ff;
  assign done_out               = done_ff;
  assign illegal_out            = illegal_ff;
  assign sr_out                 = sr_ff;
  assign first_accumulator_out  = acc_ff[0];
  assign second_accumulator_out = acc_ff[1];
  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  a_done_one_cycle: assert property (instr_in.valid |=> done_out)
    else $error("instruction did not retire in one cycle");
  a_zero_never_set: assert property ((instr_in.valid && is_lit && iw[15] && !bus_in.wr
    && !sr_ff[`SR_Z]) |=> !sr_out[`SR_Z])
    else $error("carry form set the zero flag");
  a_sac_flags_kept: assert property ((instr_in.valid && is_sac && !bus_in.wr)
    |=> sr_out[8:0] == $past(sr_ff[8:0]))
    else $error("signed add changed arithmetic flags");
  a_acc_sum_a: assert property ((instr_in.valid && is_acc && !iw[15])
    |=> first_accumulator_out == $past(acc_ff[0] + acc_ff[1]))
    else $error("accumulator add result wrong");
  a_lit_word_sum: assert property ((instr_in.valid && is_lit && !iw[14] && !bus_in.wr)
    |=> w_ff[$past(iw[3:0])] == $past(w_ff[iw[3:0]] + {6'h00, iw[13:4]}
        + {15'h0000, cin}))
    else $error("literal add result wrong");
  a_file_to_wzero: assert property ((instr_in.valid && is_file && !iw[13] && !iw[14]
    && !bus_in.wr) |=> w_ff[0] == $past(w_ff[0] + mem_ff[iw[8:1]] + {15'h0000, cin}))
    else $error("file add did not land in register zero");
  a_byte_upper_kept: assert property ((instr_in.valid && is_tri && byte_op
    && iw[13:11] == `MODE_DIR && iw[6:4] == `MODE_DIR && !bus_in.wr)
    |=> w_ff[$past(iw[10:7])][15:8] == $past(w_ff[iw[10:7]][15:8]))
    else $error("byte write touched upper byte");
  a_sac_src_kept: assert property ((instr_in.valid && is_sac && iw[6:4] == `MODE_DIR
    && !bus_in.wr) |=> w_ff[$past(iw[3:0])] == $past(w_ff[iw[3:0]]))
    else $error("shift changed source register");
  a_tri_word_sum: assert property ((instr_in.valid && is_tri && !iw[14] && !iw[19]
    && iw[13:11] == `MODE_DIR && iw[6:4] == `MODE_DIR && !bus_in.wr)
    |=> w_ff[$past(iw[10:7])] == $past(w_ff[iw[18:15]] + w_ff[iw[3:0]]))
    else $error("three-operand add result wrong");

  c_acc_add:   cover property (instr_in.valid && is_acc);
  c_sac_left:  cover property (instr_in.valid && is_sac && iw[10]);
  c_zero_kept: cover property (instr_in.valid && is_tri && iw[19] && sr_ff[`SR_Z]);
  c_byte_ind:  cover property (instr_in.valid && is_tri && byte_op && iw[13:11] != 3'h0);

endmodule : add_alu
`default_nettype wire

// ==== add_alu_pkg.sv ====
`default_nettype none
package add_alu_pkg;
  typedef logic [39:0] acc_t;
  typedef struct packed {
    logic        valid;
    logic [23:0] word;
  } instr_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic [15:0] sum;
    logic        c;
    logic        digit;
    logic        ovf;
    logic        n;
    logic        z;
  } alu_res_t;
  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] nv;
  } ea_t;
endpackage : add_alu_pkg
`default_nettype wire

// ==== add_alu_regs.svh ====
`ifndef ADD_ALU_REGS_SVH
`define ADD_ALU_REGS_SVH
// Opcode fields
`define OPC_TRI    4'h4
`define OPC_ACC    8'hCB
`define OPC_SAC    8'hC9
`define OPC_FILE   8'hB4
`define OPC_LIT    8'hB0
// Operand address modes
`define MODE_DIR   3'h0
`define MODE_IND   3'h1
`define MODE_PODEC 3'h2
`define MODE_POINC 3'h3
`define MODE_PRDEC 3'h4
`define MODE_PRINC 3'h5
// Status register bit positions
`define SR_C       0
`define SR_Z       1
`define SR_N       3
`define SR_OVF     2
`define SR_DIGIT   8
`define SR_SAT_ANY 10
`define SR_OVF_ANY 11
`define SR_SAT_2ND 12
`define SR_SAT_1ST 13
`define SR_OVF_2ND 14
`define SR_OVF_1ST 15
`define SR_RST     16'h0000
`define SAT_MASK   16'h3000
// Register port map
`define ADR_SR     10'h010
`define ADR_ACC    10'h018
`define MEM_BIT    8
`define MEM_WORDS  256
`endif

// ==== instr_feed.sv ====
`timescale 1ns/1ns
`default_nettype none
module instr_feed
  import add_alu_pkg::*;
(
  input  wire logic        clk_in,    // Core clock
  input  wire logic        rst_b_in,  // Async reset, active low
  input  wire logic        go_in,     // Issue one word
  input  wire logic [23:0] word_in,   // Word to issue
  output var  instr_t      instr_out  // Word toward the block
);
  logic [23:0] trim;  // Word with byte literal held to eight bits
  // Producer side: a byte-mode literal never carries bits above seven
  always_comb
  begin
    trim = word_in;
    if (trim[23:16] == 8'hB0 && trim[14])
      trim[13:12] = 2'h0;
  end
  // Decode stage: one registered word per request; idle word toggles so stale data never looks valid
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      instr_out <= '0;
    else if (go_in)
      instr_out <= {1'h1, trim};
    else
      instr_out <= {1'h0, ~instr_out.word};
  end
endmodule : instr_feed
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`include "add_alu_regs.svh"
`default_nettype none
module tb_top
  import add_alu_pkg::*;
;
  logic        clk_sys_in = 1'h0;
  logic        rst_b_in   = 1'h0;
  logic        go         = 1'h0;
  logic [23:0] word       = 24'h000000;
  bus_req_t    bus_in     = '0;
  instr_t      instr;
  logic [15:0] rdata;
  logic        done;
  logic        ill;
  logic [15:0] sr;
  acc_t        acc_a;
  acc_t        acc_b;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          seed       = 92451;
  int          i;
  logic [15:0] a, b, d, f, v;
  logic [31:0] e;

  // 25 MHz core clock
  always #20 clk_sys_in = ~clk_sys_in;

  instr_feed u_feed (.clk_in(clk_sys_in), .rst_b_in(rst_b_in), .go_in(go), .word_in(word),
                     .instr_out(instr));
  add_alu u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .instr_in(instr),
                 .bus_in(bus_in), .bus_rdata_out(rdata), .done_out(done), .illegal_out(ill),
                 .sr_out(sr), .first_accumulator_out(acc_a), .second_accumulator_out(acc_b));

  // Expected sum and flags {sr, result}; byte result comes zero-extended
  function automatic logic [31:0] fadd(input logic [15:0] x, y, input logic ci, bw, zin);
    logic [16:0] s;
    logic [8:0]  sl;
    logic [4:0]  sn;
    logic [15:0] r;
    logic        c, dig, ovf, n;
    s   = x + y + ci;
    sl  = x[7:0] + y[7:0] + ci;
    sn  = x[3:0] + y[3:0] + ci;
    r   = bw ? {8'h00, sl[7:0]} : s[15:0];
    c   = bw ? sl[8] : s[16];
    dig = bw ? sn[4] : sl[8];
    n   = bw ? r[7] : r[15];
    ovf = bw ? (x[7] == y[7] && r[7] != x[7]) : (x[15] == y[15] && r[15] != x[15]);
    return {7'h00, dig, 4'h0, n, ovf, zin && (r == 16'h0000), c, r};
  endfunction : fadd

  task automatic chk(input logic [39:0] g, input logic [39:0] x);
    cmp_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Register port master: one-cycle strobes, data the cycle after a read
  task automatic wr(input logic [9:0] ad, input logic [15:0] wd);
    @(posedge clk_sys_in) bus_in <= {2'h2, ad, wd};
    @(posedge clk_sys_in) bus_in <= '0;
  endtask : wr

  task automatic rchk(input logic [9:0] ad, input logic [15:0] x, input logic [15:0] m);
    @(posedge clk_sys_in) bus_in <= {2'h1, ad, 16'h0000};
    @(posedge clk_sys_in) bus_in <= '0;
    #1 chk(rdata & m, x);
  endtask : rchk

  // Issue one word; the block answers exactly one cycle after taking it
  task automatic ex(input logic [23:0] w, input logic il);
    @(posedge clk_sys_in)
    begin
      go   <= 1'h1;
      word <= w;
    end
    @(posedge clk_sys_in) go <= 1'h0;
    @(posedge clk_sys_in) #1;
    chk(done, 1'h1);
    chk(ill, il);
  endtask : ex

  // Watchdog well beyond the expected run length
  initial
  begin
    #400000;
    fail_count++;
    conclude();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'h1;
    rchk(`ADR_SR, 16'h0000, 16'hFFFF);
    chk(acc_a, 40'h0);
    // Random three-operand adds, plain and with carry, both widths
    for (i = 0; i < 24; i++)
    begin
      a = 16'($random(seed));
      b = 16'($random(seed));
      d = 16'($random(seed));
      f = 16'($random(seed));
      wr(10'h001, a);
      wr(10'h002, b);
      wr(10'h003, d);
      wr(`ADR_SR, {14'h0000, f[3], f[2]});
      ex({4'h4, f[0], 4'h1, f[1], 3'h0, 4'h3, 3'h0, 4'h2}, 1'h0);
      e = fadd(a, b, f[0] & f[2], f[1], f[0] ? f[3] : 1'h1);
      v = f[1] ? {d[15:8], e[7:0]} : e[15:0];
      rchk(10'h003, v, 16'hFFFF);
      rchk(`ADR_SR, e[31:16], 16'h010F);
    end
    // Byte carry add through post-incremented pointers
    wr(10'h000, 16'hCC20);
    wr(10'h001, 16'h0010);
    wr(10'h002, 16'h0020);
    wr(10'h108, 16'hAB25);
    wr(10'h110, 16'hFFFF);
    wr(`ADR_SR, 16'h0001);
    ex({4'h4, 1'h1, 4'h0, 1'h1, 3'h3, 4'h2, 3'h3, 4'h1}, 1'h0);
    rchk(10'h110, 16'hFF46, 16'hFFFF);
    rchk(10'h001, 16'h0011, 16'hFFFF);
    rchk(10'h002, 16'h0021, 16'hFFFF);
    rchk(`ADR_SR, 16'h0000, 16'h010F);
    // Ten-bit literal with carry; the byte literal is trimmed by the feed
    wr(10'h001, 16'h12C0);
    wr(`ADR_SR, 16'h0001);
    ex({8'hB0, 1'h1, 1'h0, 10'h0FF, 4'h1}, 1'h0);
    rchk(10'h001, 16'h13C0, 16'hFFFF);
    e = fadd(16'h12C0, 16'h00FF, 1'h1, 1'h0, 1'h0);
    rchk(`ADR_SR, e[31:16], 16'h010F);
    wr(10'h007, 16'h12C0);
    wr(`ADR_SR, 16'h0000);
    ex({8'hB0, 1'h1, 1'h1, 10'h3FF, 4'h7}, 1'h0);
    rchk(10'h007, 16'h12BF, 16'hFFFF);
    rchk(`ADR_SR, 16'h0009, 16'h010F);
    // Zero result with carry keeps Z but never sets it
    for (i = 0; i < 2; i++)
    begin
      wr(10'h001, 16'hFFFF);
      wr(`ADR_SR, {14'h0000, i[0], 1'h1});
      ex({8'hB0, 1'h1, 1'h0, 10'h000, 4'h1}, 1'h0);
      e = fadd(16'hFFFF, 16'h0000, 1'h1, 1'h0, i[0]);
      rchk(`ADR_SR, e[31:16], 16'h010F);
    end
    // File register with carry, both destinations
    wr(10'h000, 16'hCC60);
    wr(10'h180, 16'h8006);
    wr(`ADR_SR, 16'h0001);
    ex({8'hB4, 1'h1, 1'h1, 1'h1, 13'h0100}, 1'h0);
    rchk(10'h180, 16'h8067, 16'hFFFF);
    rchk(`ADR_SR, 16'h0000, 16'h010F);
    wr(10'h000, 16'h5600);
    wr(10'h120, 16'h3400);
    wr(`ADR_SR, 16'h0001);
    ex({8'hB4, 1'h1, 1'h0, 1'h0, 13'h0040}, 1'h0);
    rchk(10'h000, 16'h8A01, 16'hFFFF);
    rchk(10'h120, 16'h3400, 16'hFFFF);
    rchk(`ADR_SR, 16'h000C, 16'h010F);
    // Short literal with carry into pre-decremented and plain indirect targets
    wr(10'h003, 16'h6006);
    wr(10'h004, 16'h0042);
    wr(`ADR_SR, 16'h0001);
    ex({4'h4, 1'h1, 4'h3, 1'h0, 3'h4, 4'h4, 2'h3, 5'h06}, 1'h0);
    rchk(10'h004, 16'h0040, 16'hFFFF);
    rchk(10'h120, 16'h600D, 16'hFFFF);
    wr(10'h000, 16'hCC80);
    wr(10'h007, 16'h0030);
    wr(10'h118, 16'hB000);
    wr(`ADR_SR, 16'h0000);
    ex({4'h4, 1'h1, 4'h0, 1'h1, 3'h1, 4'h7, 2'h3, 5'h1F}, 1'h0);
    rchk(10'h118, 16'hB09F, 16'hFFFF);
    rchk(`ADR_SR, 16'h0008, 16'h010F);
    // Post-decremented source, pre-incremented destination, then a refused destination mode
    wr(10'h001, 16'h0100);
    wr(10'h002, 16'h0040);
    wr(10'h004, 16'h0050);
    wr(10'h120, 16'h1111);
    ex({4'h4, 1'h0, 4'h1, 1'h0, 3'h5, 4'h4, 3'h2, 4'h2}, 1'h0);
    rchk(10'h002, 16'h003E, 16'hFFFF);
    rchk(10'h004, 16'h0052, 16'hFFFF);
    rchk(10'h129, 16'h1211, 16'hFFFF);
    rchk(`ADR_SR, 16'h0000, 16'h010F);
    ex({4'h4, 1'h0, 4'h1, 1'h0, 3'h6, 4'h3, 3'h0, 4'h2}, 1'h1);
    rchk(10'h003, 16'h6006, 16'hFFFF);
    // Signed adds with shifts, then accumulator to accumulator
    wr(10'h000, 16'h1234);
    wr(10'h001, 16'h0001);
    wr(10'h005, 16'h0010);
    wr(10'h108, 16'hC000);
    wr(`ADR_SR, 16'h010B);
    ex({8'hC9, 1'h0, 4'h0, 4'h0, 3'h0, 4'h0}, 1'h0);
    chk(acc_a, 40'h0012340000);
    ex({8'hC9, 1'h1, 4'h0, 4'h8, 3'h0, 4'h1}, 1'h0);
    chk(acc_b, 40'h0001000000);
    ex({8'hC9, 1'h1, 4'h0, 4'h7, 3'h3, 4'h5}, 1'h0);
    chk(acc_b, 40'h0000800000);
    rchk(10'h005, 16'h0012, 16'hFFFF);
    rchk(10'h000, 16'h1234, 16'hFFFF);
    ex({8'hCB, 1'h0, 15'h0000}, 1'h0);
    chk(acc_a, 40'h0012B40000);
    ex({8'hCB, 1'h1, 15'h0000}, 1'h0);
    chk(acc_b, 40'h0013340000);
    rchk(`ADR_SR, 16'h010B, 16'hFFFF);
    // Malformed accumulator add is refused and changes nothing
    ex({8'hCB, 1'h0, 15'h0001}, 1'h1);
    chk(acc_a, 40'h0012B40000);
    // Offset-indexed signed add shifted left overflows the first accumulator
    wr(10'h008, 16'h0100);
    wr(10'h009, 16'h0002);
    wr(10'h181, 16'h7FFF);
    ex({8'hC9, 1'h0, 4'h9, 4'h8, 3'h6, 4'h8}, 1'h0);
    chk(acc_a, 40'h8011B40000);
    chk(sr, 16'hAD0B);
    rchk(10'h008, 16'h0100, 16'hFFFF);
    rchk(10'h019, 16'h11B4, 16'hFFFF);
    rchk(10'h01A, 16'h0080, 16'hFFFF);
    rchk(10'h3FF, 16'h0000, 16'hFFFF);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
